// [bench/pscl_core_tb_top.sv]
// Self-checking testbench for the synthesizer control latches.
`timescale 1ns/100ps
module pscl_core_tb_top;
   typedef struct {
      int kind;
      logic [45:0] exp;
   } pscl_note_t;

   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic clk_en = 1'b1;
   logic chip_enable = 1'b1;
   logic pdet_cycle = 1'b0;
   logic err_below_15ns = 1'b0;
   logic err_above_25ns = 1'b0;
   logic serial_clk;
   logic serial_data;
   logic load_strobe;
   pscl_pkg::pscl_ctrl_t ctrl;
   logic digital_lock;
   logic selectable_test_output;
   logic [23:0] ref_w = 24'h000000;
   logic [23:0] fb_w = 24'h000000;
   logic [23:0] fn_w = 24'h000000;
   logic pd_hit = 1'b0;
   logic lk = 1'b0;
   int fails = 0;
   int n_checks = 0;
   pscl_note_t notes[$];
   event chk_ev;

   always #4 clk = ~clk;

   pscl_host_model host_u (
      .serial_clk(serial_clk),
      .serial_data(serial_data),
      .load_strobe(load_strobe)
   );

   pscl_core dut_u (
      .clk(clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .serial_clk(serial_clk),
      .serial_data(serial_data),
      .load_strobe(load_strobe),
      .chip_enable(chip_enable),
      .pdet_cycle(pdet_cycle),
      .err_below_15ns(err_below_15ns),
      .err_above_25ns(err_above_25ns),
      .ctrl(ctrl),
      .digital_lock(digital_lock),
      .selectable_test_output(selectable_test_output)
   );

   // ******************************
   // Expected values and checking
   // ******************************
   function automatic logic [45:0] exp_ctrl();
      logic fl;
      logic pd;
      fl = fn_w[9] & fb_w[21];
      pd = ~chip_enable | (fn_w[3] & ~fn_w[21]) | (fn_w[3] & fn_w[21] & pd_hit);
      // The delay choice only matters while resynchronization is on, so it reads as 0 otherwise.
      return {ref_w[15:2], ref_w[17:16], ref_w[21], ref_w[21] & ref_w[22], fb_w[7:2], fb_w[20:8], fn_w[23:22],
         fl ? fn_w[20:18] : fn_w[17:15], fn_w[8] | fn_w[2] | pd, fn_w[2], pd, fl};
   endfunction

   task automatic check(input string what, input logic [45:0] seen, input logic [45:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic expect_all();
      notes.push_back('{0, exp_ctrl()});
      notes.push_back('{1, {45'h0, lk}});
      notes.push_back('{2, {45'h0, lk & (fn_w[6:4] == pscl_pkg::MUX_LOCK)}});
      @(negedge clk);
      ->chk_ev;
   endtask

   always
   begin
      @(chk_ev);
      while (notes.size() > 0)
      begin
         pscl_note_t n;
         n = notes.pop_front();
         if (n.kind == 0)
            check("ctrl", ctrl, n.exp);
         else if (n.kind == 1)
            check("digital_lock", {45'h0, digital_lock}, n.exp);
         else
            check("test_output", {45'h0, selectable_test_output}, n.exp);
      end
   end

   // ******************************
   // Stimulus
   // ******************************
   task automatic wr(input logic [23:0] w, input int half);
      host_u.send_word(w, half);
      case (w[1:0])
         2'h0: ref_w = w;
         2'h1: fb_w = w;
         default:
         begin
            fn_w = w;
            pd_hit = 1'b0;
         end
      endcase
      repeat (6) @(negedge clk);
   endtask

   task automatic det(input logic good, input logic bad);
      err_below_15ns = good;
      err_above_25ns = bad;
      repeat (2) @(negedge clk);
      pdet_cycle = 1'b1;
      repeat (4) @(negedge clk);
      pdet_cycle = 1'b0;
      repeat (4) @(negedge clk);
   endtask

   function automatic logic [23:0] rnd_ref(input logic lp);
      return {1'b0, 2'($urandom), lp, 2'h0, 2'($urandom), 14'($urandom), 2'h0};
   endfunction

   function automatic logic [23:0] rnd_fb(input logic gain);
      return {2'h0, gain, 13'($urandom_range(8191, 64)), 6'($urandom), 2'h1};
   endfunction

   // Prescaler and both current settings are random; the caller sets the rest.
   function automatic logic [23:0] fnw(input logic [23:0] set);
      return (24'($urandom) & 24'hDF8000) | set | 24'h000002;
   endfunction

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      #300000;
      fails++;
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(14753));
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      expect_all();
      $display("test reset done");
      wr(fnw(24'h000004), 32);
      expect_all();
      wr(rnd_ref(1'b0), 32);
      expect_all();
      wr(rnd_fb(1'b0), 32);
      expect_all();
      wr(fnw(24'h000010), 32);
      expect_all();
      $display("test startup done");
      for (int i = 1; i <= 3; i++)
      begin
         det(1'b1, 1'b0);
         lk = (i == 3);
         expect_all();
      end
      det(1'b0, 1'b1);
      lk = 1'b0;
      expect_all();
      wr(rnd_ref(1'b1), 32);
      for (int i = 1; i <= 5; i++)
      begin
         det(1'b1, 1'b0);
         lk = (i == 5);
         expect_all();
      end
      $display("test lock done");
      wr(fnw(24'h000210), 32);
      wr(rnd_fb(1'b1), 32);
      expect_all();
      wr(rnd_fb(1'b0), 32);
      expect_all();
      for (int c = 0; c < 3; c += 2)
      begin
         wr(fnw(24'h000610 | (24'(c) << 11)), 32);
         wr(rnd_fb(1'b1), 32);
         repeat (4 * c + 2) det(1'b1, 1'b0);
         expect_all();
         det(1'b1, 1'b0);
         fb_w[21] = 1'b0;
         expect_all();
      end
      $display("test fastlock done");
      wr(fnw(24'h000018), 32);
      expect_all();
      // Power back up first, so the deferred mode has a detector cycle to wait for.
      wr(fnw(24'h000010), 32);
      expect_all();
      wr(fnw(24'h200018), 32);
      expect_all();
      det(1'b1, 1'b0);
      pd_hit = 1'b1;
      expect_all();
      wr(fnw(24'h000110), 32);
      expect_all();
      chip_enable = 1'b0;
      repeat (4) @(negedge clk);
      expect_all();
      wr(rnd_ref(1'b1), 32);
      expect_all();
      chip_enable = 1'b1;
      wr(fnw(24'h000013), 32);
      expect_all();
      $display("test power done");
      // A large-error detector cycle while frozen must not reach the lock logic.
      clk_en = 1'b0;
      det(1'b0, 1'b1);
      expect_all();
      clk_en = 1'b1;
      $display("test freeze done");
      repeat (4) @(negedge clk);
      tally_and_finish();
   end
endmodule

// [bench/pscl_host_model.sv]
// Host controller model that shifts control words over the three-wire serial port.
`timescale 1ns/100ps
module pscl_host_model (
   output logic serial_clk, // serial clock to the device
   output logic serial_data, // serial data to the device
   output logic load_strobe // load strobe to the device
);
   initial
   begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end

   // msb first
   // The odd start offset keeps the serial clock out of phase with the system clock.
   task automatic send_word(input logic [23:0] w, input int half);
      #1.7;
      for (int i = 23; i >= 0; i--)
      begin
         serial_data = w[i];
         #(half) serial_clk = 1'b1;
         #(half) serial_clk = 1'b0;
      end
      // A released data line shows the inverse bit, so a stale value never reads as valid.
      serial_data = ~w[0];
      #(half) load_strobe = 1'b1;
      #(half) load_strobe = 1'b0;
   endtask
endmodule

// [src/pscl_core.sv]
// Serial control port, control latches, lock detect, power-down and fastlock sequencing.
// Overview of operation
// RQ1: 24-bit word shifted in MSB first.
// RQ2: strobe rising edge transfers word to latch.
// RQ3: low two bits choose one of four latches.
// RQ4: reference bits 2..15 hold divide value.
// RQ5: reference bits 16..17 select backlash width.
// RQ6: bit 20 picks three or five cycles.
// RQ7: good cycles count; bad cycle drops lock.
// RQ8: bits 21/22 select resync and delay.
// RQ9: feedback bits 2..7 hold A value.
// RQ10: feedback bits 8..20 hold B value.
// RQ11: host keeps B not below A.
// RQ12: feedback bit 21 enters or leaves fastlock.
// RQ13: counter reset holds counters, three-states pump.
// RQ14: chip enable low powers down, port live.
// RQ15: software power-down, immediate or next cycle.
// RQ16: bits 4..6 select the test output.
// RQ17: function bit 8 three-states charge pump.
// RQ18: bit 9 enables fastlock, bit 10 mode.
// RQ19: mode 2 expiry clears gain bit.
// RQ20: timeout field counts detector cycles.
// RQ21: timeout is four times field plus three.
// RQ22: current 1 steady, current 2 in fastlock.
// RQ23: bits 22..23 select prescaler modulus.
// RQ24: init latch like function, one counter reset.
// RQ25: host sequence for counter-reset start-up.
// RQ26: whole word applied in one cycle.
`timescale 1ns/100ps
module pscl_core (
   input wire logic clk, // system clock, 125 MHz
   input wire logic nrst, // synchronous reset, active low
   input wire logic clk_en, // freezes all state while low
   input wire logic serial_clk, // serial clock pin
   input wire logic serial_data, // serial data pin
   input wire logic load_strobe, // load strobe pin
   input wire logic chip_enable, // chip enable pin, low powers down
   input wire logic pdet_cycle, // detector cycle marker, rising edge per cycle
   input wire logic err_below_15ns, // phase error of the cycle is small
   input wire logic err_above_25ns, // phase error of the cycle is large
   output pscl_pkg::pscl_ctrl_t ctrl, // registered controls for the analog section
   output logic digital_lock, // lock indication, active high
   output logic selectable_test_output // multiplexed test output
);

   // ************************************************************
   // Pin synchronization and edge detection
   // ************************************************************
   logic [6:0] pins_s;
   logic sck_s;
   logic sdata_s;
   logic strobe_s;
   logic ce_s;
   logic pdet_s;
   logic good_s;
   logic bad_s;
   logic sck_prev_q;
   logic strobe_prev_q;
   logic pdet_prev_q;
   logic sck_rise;
   logic strobe_rise;
   logic pdet_rise;

   pscl_sync #(.W(7)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .raw_level({serial_clk, serial_data, load_strobe, chip_enable, pdet_cycle, err_below_15ns, err_above_25ns}),
      .stable_level(pins_s)
   );

   assign {sck_s, sdata_s, strobe_s, ce_s, pdet_s, good_s, bad_s} = pins_s;
   assign sck_rise = sck_s && !sck_prev_q;
   assign strobe_rise = strobe_s && !strobe_prev_q;
   assign pdet_rise = pdet_s && !pdet_prev_q;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sck_prev_q <= 1'b0;
         strobe_prev_q <= 1'b0;
         pdet_prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
         sck_prev_q <= sck_s;
         strobe_prev_q <= strobe_s;
         pdet_prev_q <= pdet_s;
      end
   end

   // ************************************************************
   // Shift register and latch transfer
   // ************************************************************
   logic [23:0] shift_q;
   pscl_pkg::pscl_ref_t ref_q;
   pscl_pkg::pscl_fb_t fb_q;
   pscl_pkg::pscl_fn_t fn_q;
   pscl_pkg::pscl_fb_t shift_fb;
   logic init_pulse_q;
   logic wr_ref;
   logic wr_fb;
   logic wr_fn;
   logic wr_init;

   // RQ3: latch decode
   assign wr_ref = strobe_rise && (shift_q[1:0] == pscl_pkg::SEL_REF);
   assign wr_fb = strobe_rise && (shift_q[1:0] == pscl_pkg::SEL_FB);
   assign wr_fn = strobe_rise && (shift_q[1:0] == pscl_pkg::SEL_FN);
   assign wr_init = strobe_rise && (shift_q[1:0] == pscl_pkg::SEL_INIT);
   assign shift_fb = pscl_pkg::pscl_fb_t'(shift_q);

   // RQ1: MSB first shift
   always_ff @(posedge clk)
   begin
      if (!nrst)
         shift_q <= 24'h000000;
      else if (clk_en && sck_rise)
         shift_q <= {shift_q[22:0], sdata_s};
   end

   // The strobe is resampled on clk, so a word lands in its latch in a single
   // cycle and the divider outputs never show a half-written value.
   // RQ2: transfer on strobe edge
   // RQ26: atomic word update
   // RQ24: init latch shares function layout
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ref_q <= pscl_pkg::REF_RST;
         fb_q <= pscl_pkg::FB_RST;
         fn_q <= pscl_pkg::FN_RST;
         init_pulse_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (wr_ref)
            ref_q <= shift_q;
         if (wr_fb)
            fb_q <= shift_q;
         if (wr_fn || wr_init)
            fn_q <= shift_q;
         init_pulse_q <= wr_init;
      end
   end

   // ************************************************************
   // Digital lock detect
   // ************************************************************
   logic [2:0] lock_cnt_q;
   logic lock_q;
   logic [2:0] lock_need;
   logic [2:0] lock_cnt_inc;

   // RQ6: precision select
   assign lock_need = ref_q.lock_precision ? pscl_pkg::LOCK_MANY : pscl_pkg::LOCK_FEW;
   assign lock_cnt_inc = (lock_cnt_q >= lock_need) ? lock_cnt_q : lock_cnt_q + 3'h1;

   // A middle-band cycle breaks the run without dropping lock already held.
   // RQ7: qualify and drop
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         lock_cnt_q <= 3'h0;
         lock_q <= 1'b0;
      end
      else if (clk_en && pdet_rise)
      begin
         if (bad_s)
         begin
            lock_cnt_q <= 3'h0;
            lock_q <= 1'b0;
         end
         else if (good_s)
         begin
            lock_cnt_q <= lock_cnt_inc;
            if (lock_cnt_inc >= lock_need)
               lock_q <= 1'b1;
         end
         else
            lock_cnt_q <= 3'h0;
      end
   end

   // ************************************************************
   // Power-down and fastlock sequencing
   // ************************************************************
   logic pd_q;
   logic pd_d;
   logic gain_q;
   logic gain_d;
   logic fl_active_q;
   logic tmr_start;
   logic tmr_stop;
   logic tmr_expired;

   // Chip enable passes the synchronizer, so the hardware power-down in pd_q lags
   // the pin by three clocks; the serial port keeps running throughout.
   // RQ14: hardware power-down
   // RQ15: software power-down modes
   assign pd_d = !ce_s ? 1'b1 :
                 !fn_q.pd_req ? 1'b0 :
                 !fn_q.pd_sync_mode ? 1'b1 :
                 (pdet_rise || pd_q);

   // A host write of the gain bit wins over a timer clear in the same cycle.
   // RQ12: gain bit from host
   // RQ19: expiry clears gain
   assign gain_d = wr_fb ? shift_fb.cp_gain : (tmr_expired ? 1'b0 : gain_q);

   // RQ18: enable and mode
   assign tmr_start = wr_fb && shift_fb.cp_gain && fn_q.fl_en && fn_q.fl_mode2;
   assign tmr_stop = !fn_q.fl_en || !fn_q.fl_mode2 || !gain_q;

   pscl_fl_timer u_timer (
      .clk(clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .start(tmr_start),
      .stop(tmr_stop),
      .tick(pdet_rise),
      .code(fn_q.fl_timer),
      .running(),
      .expired(tmr_expired)
   );

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         pd_q <= 1'b1;
         gain_q <= 1'b0;
         fl_active_q <= 1'b0;
      end
      else if (clk_en)
      begin
         pd_q <= pd_d;
         gain_q <= gain_d;
         fl_active_q <= fn_q.fl_en && gain_d;
      end
   end

   // ************************************************************
   // Output registers
   // ************************************************************
   pscl_pkg::pscl_ctrl_t ctrl_d;
   logic counters_held;
   logic mux_d;

   // RQ13: counter reset
   // RQ24: one-shot reset
   assign counters_held = fn_q.counter_reset || init_pulse_q;
   // RQ16: lock on test output
   assign mux_d = (fn_q.mux_sel == pscl_pkg::MUX_LOCK) && lock_q;

   // RQ4: reference divide value
   assign ctrl_d.ref_div = ref_q.ref_div;
   // RQ5: backlash width
   assign ctrl_d.backlash_width = ref_q.backlash_width;
   // RQ8: resync and delay
   assign ctrl_d.resync_en = ref_q.resync_en;
   assign ctrl_d.resync_delay_select = ref_q.resync_en && ref_q.resync_delay_select;
   // RQ9: A value
   assign ctrl_d.a_val = fb_q.a_val;
   // RQ10: B value
   assign ctrl_d.b_val = fb_q.b_val;
   // RQ23: prescaler modulus
   assign ctrl_d.prescaler = fn_q.prescaler;
   // RQ22: current selection
   assign ctrl_d.cp_current = fl_active_q ? fn_q.cp_current2 : fn_q.cp_current1;
   // RQ17: forced three-state
   assign ctrl_d.cp_tristate = fn_q.cp_tristate || counters_held || pd_q;
   assign ctrl_d.counter_reset = counters_held;
   assign ctrl_d.power_down = pd_q;
   assign ctrl_d.fastlock_active = fl_active_q;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ctrl <= '0;
         digital_lock <= 1'b0;
         selectable_test_output <= 1'b0;
      end
      else if (clk_en)
      begin
         ctrl <= ctrl_d;
         digital_lock <= lock_q;
         selectable_test_output <= mux_d;
      end
   end

   // ************************************************************
   // Assertions and cover points
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || !clk_en);

   shift_msb_first_a: assert property (sck_rise |=> shift_q[0] == $past(sdata_s) && shift_q[23:1] == $past(shift_q[22:0])) // RQ1
      else $error("serial bit not shifted in");
   latch_select_a: assert property (wr_ref |=> ref_q == $past(shift_q) && $stable(fb_q) && $stable(fn_q)) // RQ3
      else $error("wrong latch written");
   ref_div_out_a: assert property (wr_ref |=> ##1 ctrl.ref_div == $past(shift_q[15:2], 2)) // RQ4
      else $error("reference divide value not applied");
   lock_drop_a: assert property (pdet_rise && bad_s |=> !lock_q ##1 !digital_lock) // RQ7
      else $error("lock kept after large error");
   lock_count_a: assert property ($rose(lock_q) |-> $past(lock_cnt_q) + 3'h1 >= $past(lock_need)) // RQ6
      else $error("lock asserted too early");
   gain_cleared_a: assert property (tmr_expired && !wr_fb |=> !gain_q ##1 !ctrl.fastlock_active) // RQ19
      else $error("gain bit not cleared on timeout");
   fl_current_a: assert property (fl_active_q |=> ctrl.cp_current == $past(fn_q.cp_current2)) // RQ22
      else $error("fastlock current not used");
   hw_powerdown_a: assert property (!ce_s |-> ##2 ctrl.power_down && ctrl.cp_tristate) // RQ14
      else $error("chip enable low did not power down");
   sw_powerdown_a: assert property (ce_s && fn_q.pd_req && !fn_q.pd_sync_mode |=> pd_q) // RQ15
      else $error("immediate power-down missed");
   reset_tristate_a: assert property (fn_q.counter_reset |=> ctrl.counter_reset && ctrl.cp_tristate) // RQ13
      else $error("counter reset not held");
   init_once_a: assert property (wr_init |=> init_pulse_q ##1 !init_pulse_q || $past(wr_init)) // RQ24
      else $error("init reset pulse wrong length");

   lock_seen_c: cover property ($rose(digital_lock));
   mode2_exit_c: cover property (tmr_expired);
   sync_pd_c: cover property (fn_q.pd_sync_mode && $rose(pd_q));
endmodule

// [src/pscl_fl_timer.sv]
// Fastlock mode-2 timeout counter, counted in detector cycles.
`timescale 1ns/100ps
module pscl_fl_timer (
   input wire logic clk, // system clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic clk_en, // freezes state while low
   input wire logic start, // load and run
   input wire logic stop, // abandon the count
   input wire logic tick, // one detector cycle
   input wire logic [3:0] code, // timeout field
   output logic running, // count in progress
   output logic expired // pulse on the last cycle
);
   logic [5:0] cnt_q;
   logic run_q;
   logic [5:0] load_val;
   logic last_tick;

   // RQ21: four times field plus three
   assign load_val = 6'({code, 2'h0}) + pscl_pkg::TMR_BASE;
   assign last_tick = run_q && tick && (cnt_q == 6'h01);
   assign expired = last_tick;
   assign running = run_q;

   // RQ20: counts detector cycles
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cnt_q <= 6'h00;
         run_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (start)
         begin
            cnt_q <= load_val;
            run_q <= 1'b1;
         end
         else if (stop || last_tick)
            run_q <= 1'b0;
         else if (run_q && tick)
            cnt_q <= cnt_q - 6'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || !clk_en);

   timer_load_value_a: assert property (start |=> cnt_q == 6'({$past(code), 2'h0}) + 6'h03) // RQ21
      else $error("timer loaded with wrong count");
   timer_stops_a: assert property (last_tick |=> !run_q) // RQ20
      else $error("timer kept running after expiry");
endmodule

// [src/pscl_pkg.sv]
// Shared latch layouts, selector codes and counts for the synthesizer control latches.
package pscl_pkg;

   localparam int WORD_W = 24;

   // Latch selector codes carried in the two lowest word bits.
   localparam logic [1:0] SEL_REF = 2'h0;
   localparam logic [1:0] SEL_FB = 2'h1;
   localparam logic [1:0] SEL_FN = 2'h2;
   localparam logic [1:0] SEL_INIT = 2'h3;

   // Reset values of the three stored latches.
   localparam logic [23:0] REF_RST = 24'h000000;
   localparam logic [23:0] FB_RST = 24'h000000;
   localparam logic [23:0] FN_RST = 24'h000000;

   // Contiguous good detector cycles needed for lock.
   localparam logic [2:0] LOCK_FEW = 3'h3;
   localparam logic [2:0] LOCK_MANY = 3'h5;

   // Multiplexer code for the lock indication: bit4=1, bit5=0, bit6=0.
   localparam logic [2:0] MUX_LOCK = 3'h1;

   // Fastlock timeout is step times field plus base, in detector cycles.
   localparam logic [5:0] TMR_BASE = 6'h03;

   typedef struct packed {
      logic spare23;
      logic resync_delay_select;
      logic resync_en;
      logic lock_precision;
      logic [1:0] spare19_18;
      logic [1:0] backlash_width;
      logic [13:0] ref_div;
      logic [1:0] sel;
   } pscl_ref_t;

   typedef struct packed {
      logic [1:0] spare23_22;
      logic cp_gain;
      logic [12:0] b_val;
      logic [5:0] a_val;
      logic [1:0] sel;
   } pscl_fb_t;

   typedef struct packed {
      logic [1:0] prescaler;
      logic pd_sync_mode;
      logic [2:0] cp_current2;
      logic [2:0] cp_current1;
      logic [3:0] fl_timer;
      logic fl_mode2;
      logic fl_en;
      logic cp_tristate;
      logic spare7;
      logic [2:0] mux_sel;
      logic pd_req;
      logic counter_reset;
      logic [1:0] sel;
   } pscl_fn_t;

   typedef struct packed {
      logic [13:0] ref_div;
      logic [1:0] backlash_width;
      logic resync_en;
      logic resync_delay_select;
      logic [5:0] a_val;
      logic [12:0] b_val;
      logic [1:0] prescaler;
      logic [2:0] cp_current;
      logic cp_tristate;
      logic counter_reset;
      logic power_down;
      logic fastlock_active;
   } pscl_ctrl_t;

endpackage

// [src/pscl_sync.sv]
// Two-stage synchronizer for pins arriving from outside the clock domain.
`timescale 1ns/100ps
module pscl_sync #(parameter int W = 1) (
   input wire logic clk, // system clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic clk_en, // freezes state while low
   input wire logic [W-1:0] raw_level, // unsynchronized pins
   output logic [W-1:0] stable_level // synchronized copy
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         meta_q <= '0;
         stable_level <= '0;
      end
      else if (clk_en)
      begin
         meta_q <= raw_level;
         stable_level <= meta_q;
      end
   end
endmodule
